// File: inc/crc_gen_pkg.sv
// Purpose: Shared constants for the programmable CRC generator
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes: Register layouts follow the control and polynomial registers
package crc_gen_pkg;

    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [11:0] OFF_CONTROL = 12'h000;
    localparam logic [11:0] OFF_POLY = 12'h004;
    localparam logic [11:0] OFF_WDATA = 12'h008;
    localparam logic [11:0] OFF_RESULT = 12'h00C;
    localparam logic [11:0] OFF_IRQ_STAT = 12'h010;
    localparam logic [11:0] OFF_IRQ_MASK = 12'h014;
    localparam logic [11:0] OFF_POWER = 12'h018;

    // ----------------------------------------
    // Control and power register fields
    // ----------------------------------------
    localparam int CTL_IDLE_BIT = 13;
    localparam int CTL_COUNT_LSB = 8;
    localparam int CTL_FULL_BIT = 7;
    localparam int CTL_EMPTY_BIT = 6;
    localparam int CTL_GO_BIT = 4;
    localparam int CTL_LEN_LSB = 0;
    localparam int LEN_W = 4;
    localparam int COUNT_W = 5;
    localparam int POWER_SLEEP_BIT = 0;
    localparam int POWER_IDLE_BIT = 1;

    // ----------------------------------------
    // Widths, depths and reset values
    // ----------------------------------------
    localparam int CRC_W = 16;
    localparam int DEPTH_MAX = 16;
    localparam logic [COUNT_W-1:0] DEPTH_SHORT = 5'h10;
    localparam logic [COUNT_W-1:0] DEPTH_LONG = 5'h08;
    localparam logic [LEN_W-1:0] LEN_SHORT_MAX = 4'h7;
    localparam logic [CRC_W-1:0] POLY_USED_MASK = 16'hFFFE;
    localparam logic [CRC_W-1:0] RESET_POLY = 16'h0000;
    localparam logic [CRC_W-1:0] RESET_CRC = 16'h0000;
    localparam logic [COUNT_W-1:0] COUNT_ZERO = 5'h00;
    localparam logic [COUNT_W-1:0] COUNT_ONE = 5'h01;

endpackage : crc_gen_pkg

// File: design/crc_shift_engine.sv
// Purpose: One-bit-per-clock CRC shift register with programmable taps
// Assumes: Caller pulses shiftEn once per data bit, MSb first
// Notes: Taps above the programmed length are ignored
`timescale 1ns/1ps
module crc_shift_engine #(
    parameter int WIDTH = crc_gen_pkg::CRC_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic shiftEn,
    input wire logic dataBit,
    input wire logic [3:0] lenM1,
    input wire logic [WIDTH-1:0] taps,
    output logic [WIDTH-1:0] crcValue
);

    logic [WIDTH-1:0] crc_q;
    logic [WIDTH-1:0] crc_d;
    logic feedback;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        feedback = crc_q[lenM1] ^ dataBit;
        crc_d = crc_q;
        for (int n = 0; n < WIDTH; n++) begin
            if (n == 0) begin
                crc_d[n] = feedback;
            end else if (n <= int'(lenM1)) begin
                crc_d[n] = crc_q[n-1] ^ (taps[n] & feedback);
            end else begin
                crc_d[n] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            crc_q <= crc_gen_pkg::RESET_CRC;
        end else if (shiftEn) begin
            crc_q <= crc_d;
        end
    end

    assign crcValue = crc_q;

endmodule : crc_shift_engine

// File: design/crc_generator.sv
// Purpose: APB-attached programmable CRC generator with data FIFO
// Assumes: Single 250 MHz clock, synchronous active-low reset
// Notes: Sleep and idle arrive as level inputs from power management
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ps
module crc_generator (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sleepReq,
    input wire logic idleReq,
    output logic irq
);

    localparam int DW = crc_gen_pkg::CRC_W;
    localparam int CW = crc_gen_pkg::COUNT_W;
    localparam int LW = crc_gen_pkg::LEN_W;

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic stopInIdle_q;
    logic go_q;
    logic [LW-1:0] lenM1_q;
    logic [DW-1:0] poly_q;
    logic [DW-1:0] fifoMem_q [crc_gen_pkg::DEPTH_MAX];
    logic [3:0] wrPtr_q;
    logic [3:0] rdPtr_q;
    logic [CW-1:0] count_q;
    logic [3:0] bitIdx_q;
    typedef enum logic [1:0] {
        SH_IDLE = 2'b00,
        SH_RUN = 2'b01,
        SH_DRAIN = 2'b10
    } shift_state_t;
    shift_state_t shState_q;
    shift_state_t shState_d;
    logic irqStat_q;
    logic irqMask_q;
    logic irq_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [DW-1:0] crcValue;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    logic access;
    logic wrAcc;
    logic rdAcc;
    logic lowLanes;
    logic mapped;
    assign access = psel && penable && !pready_q;
    assign wrAcc = access && pwrite;
    assign rdAcc = access && !pwrite;
    assign lowLanes = pstrb[0] && pstrb[1];
    always_comb begin
        unique case (paddr)
            crc_gen_pkg::OFF_CONTROL,
            crc_gen_pkg::OFF_POLY,
            crc_gen_pkg::OFF_WDATA,
            crc_gen_pkg::OFF_RESULT,
            crc_gen_pkg::OFF_IRQ_STAT,
            crc_gen_pkg::OFF_IRQ_MASK,
            crc_gen_pkg::OFF_POWER: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // ----------------------------------------
    // Run enable: sleep, or idle with stop bit, freezes the shifter and FIFO state
    // ----------------------------------------
    logic runEn;
    assign runEn = !sleepReq && !(idleReq && stopInIdle_q);

    // ----------------------------------------
    // FIFO depth and flags
    // ----------------------------------------
    logic [CW-1:0] depth;
    logic full;
    logic empty;
    assign depth = (lenM1_q > crc_gen_pkg::LEN_SHORT_MAX) ? crc_gen_pkg::DEPTH_LONG
                                                           : crc_gen_pkg::DEPTH_SHORT;
    assign full = (count_q >= depth);
    assign empty = (count_q == crc_gen_pkg::COUNT_ZERO);

    // ----------------------------------------
    // Shifter control
    // ----------------------------------------
    logic msbLane;
    logic dataWrite;
    logic shiftNow;
    logic wordDone;
    logic lastWord;
    logic [DW-1:0] headWord;
    logic dataBit;
    // A word counts only when the byte lane holding its top bit is written
    assign msbLane = (lenM1_q > crc_gen_pkg::LEN_SHORT_MAX) ? pstrb[1] : pstrb[0];
    assign dataWrite = wrAcc && (paddr == crc_gen_pkg::OFF_WDATA) && runEn && msbLane;
    assign shiftNow = runEn && (go_q || shState_q != SH_IDLE) && !empty;
    assign wordDone = shiftNow && (bitIdx_q == 4'h0);
    assign lastWord = wordDone && !dataWrite && (count_q == crc_gen_pkg::COUNT_ONE);
    assign headWord = fifoMem_q[rdPtr_q];
    assign dataBit = headWord[bitIdx_q];

    // ----------------------------------------
    // Shifter state
    // ----------------------------------------
    // Drain state lets the FIFO empty after go is cleared
    always_comb begin
        shState_d = shState_q;
        unique case (shState_q)
            SH_IDLE: begin
                if (go_q && !empty && !lastWord) begin
                    shState_d = SH_RUN;
                end
            end
            SH_RUN: begin
                if (empty || lastWord) begin
                    shState_d = SH_IDLE;
                end else if (!go_q) begin
                    shState_d = SH_DRAIN;
                end
            end
            SH_DRAIN: begin
                if (empty || lastWord) begin
                    shState_d = SH_IDLE;
                end else if (go_q) begin
                    shState_d = SH_RUN;
                end
            end
            default: shState_d = SH_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shState_q <= SH_IDLE;
        end else if (runEn) begin
            shState_q <= shState_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bitIdx_q <= 4'h0;
        end else if (runEn) begin
            if (!shiftNow) begin
                bitIdx_q <= lenM1_q;
            end else if (wordDone) begin
                bitIdx_q <= lenM1_q;
            end else begin
                bitIdx_q <= bitIdx_q - 4'h1;
            end
        end
    end

    crc_shift_engine #(
        .WIDTH(DW)
    ) u_engine (
        .clk(clk),
        .rst_n(rst_n),
        .shiftEn(shiftNow),
        .dataBit(dataBit),
        .lenM1(lenM1_q),
        .taps(poly_q),
        .crcValue(crcValue)
    );

    // ----------------------------------------
    // FIFO storage and pointers
    // ----------------------------------------
    // Ring of sixteen entries; a long length only lowers the full mark
    always_ff @(posedge clk) begin
        if (dataWrite && !full) begin
            fifoMem_q[wrPtr_q] <= pwdata[DW-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wrPtr_q <= 4'h0;
            rdPtr_q <= 4'h0;
            count_q <= crc_gen_pkg::COUNT_ZERO;
        end else if (dataWrite && full) begin
            // Write while full drops every held word, no drain event
            wrPtr_q <= 4'h0;
            rdPtr_q <= 4'h0;
            count_q <= crc_gen_pkg::COUNT_ZERO;
        end else if (runEn) begin
            if (dataWrite) begin
                wrPtr_q <= wrPtr_q + 4'h1;
            end
            if (wordDone) begin
                rdPtr_q <= rdPtr_q + 4'h1;
            end
            unique case ({dataWrite, wordDone})
                2'b10: count_q <= count_q + crc_gen_pkg::COUNT_ONE;
                2'b01: count_q <= count_q - crc_gen_pkg::COUNT_ONE;
                2'b00, 2'b11: count_q <= count_q;
            endcase
        end
    end

    // ----------------------------------------
    // Interrupt: drain event, sticky status, mask
    // ----------------------------------------
    logic drainEvt;
    logic clrStat;
    assign drainEvt = lastWord;
    assign clrStat = wrAcc && (paddr == crc_gen_pkg::OFF_IRQ_STAT) && pstrb[0] && pwdata[0];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irqStat_q <= 1'b0;
        end else if (drainEvt) begin
            irqStat_q <= 1'b1;
        end else if (clrStat) begin
            irqStat_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irqMask_q <= 1'b0;
        end else if (wrAcc && paddr == crc_gen_pkg::OFF_IRQ_MASK && pstrb[0]) begin
            irqMask_q <= pwdata[0];
        end
    end

    // Runs regardless of run enable so pending events still leave
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= (irqStat_q || drainEvt) && irqMask_q;
        end
    end

    // ----------------------------------------
    // Control and polynomial registers
    // ----------------------------------------
    // Status fields of the control word are read-only and ignore writes
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stopInIdle_q <= 1'b0;
            go_q <= 1'b0;
            lenM1_q <= 4'h0;
        end else if (wrAcc && paddr == crc_gen_pkg::OFF_CONTROL) begin
            if (pstrb[1]) begin
                stopInIdle_q <= pwdata[crc_gen_pkg::CTL_IDLE_BIT];
            end
            if (pstrb[0]) begin
                go_q <= pwdata[crc_gen_pkg::CTL_GO_BIT];
                lenM1_q <= pwdata[crc_gen_pkg::CTL_LEN_LSB +: LW];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            poly_q <= crc_gen_pkg::RESET_POLY;
        end else if (wrAcc && paddr == crc_gen_pkg::OFF_POLY && lowLanes) begin
            poly_q <= pwdata[DW-1:0] & crc_gen_pkg::POLY_USED_MASK;
        end
    end

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    logic [31:0] rdMux;
    always_comb begin
        rdMux = 32'h0000_0000;
        unique case (paddr)
            crc_gen_pkg::OFF_CONTROL: begin
                rdMux[crc_gen_pkg::CTL_IDLE_BIT] = stopInIdle_q;
                rdMux[crc_gen_pkg::CTL_COUNT_LSB +: CW] = count_q;
                rdMux[crc_gen_pkg::CTL_FULL_BIT] = full;
                rdMux[crc_gen_pkg::CTL_EMPTY_BIT] = empty;
                rdMux[crc_gen_pkg::CTL_GO_BIT] = go_q;
                rdMux[crc_gen_pkg::CTL_LEN_LSB +: LW] = lenM1_q;
            end
            crc_gen_pkg::OFF_POLY: rdMux[DW-1:0] = poly_q;
            crc_gen_pkg::OFF_WDATA, crc_gen_pkg::OFF_RESULT: rdMux[DW-1:0] = crcValue;
            crc_gen_pkg::OFF_IRQ_STAT: rdMux[0] = irqStat_q;
            crc_gen_pkg::OFF_IRQ_MASK: rdMux[0] = irqMask_q;
            crc_gen_pkg::OFF_POWER: begin
                rdMux[crc_gen_pkg::POWER_SLEEP_BIT] = sleepReq;
                rdMux[crc_gen_pkg::POWER_IDLE_BIT] = !runEn;
            end
            default: rdMux = 32'h0000_0000;
        endcase
    end

    // ----------------------------------------
    // APB answer: one wait state, pready one cycle
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= access;
            pslverr_q <= access && !mapped;
            if (rdAcc) begin
                prdata_q <= rdMux;
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq = irq_q;

endmodule : crc_generator

// File: testbench/crc_generator_chk.sv
// Purpose: Port-level assertions for the CRC generator
// Assumes: APB read data valid in the pready cycle
// Notes: Bound to every crc_generator instance
`timescale 1ns/1ps
module crc_generator_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq
);
    // ----------------------------------------
    // Read decode and properties
    // ----------------------------------------
    logic rdCtl, rdPoly;
    assign rdCtl = psel && penable && pready && !pwrite && paddr == crc_gen_pkg::OFF_CONTROL;
    assign rdPoly = psel && penable && pready && !pwrite && paddr == crc_gen_pkg::OFF_POLY;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property flagsApart;
        rdCtl |-> !(prdata[7] && prdata[6]);
    endproperty
    ctl_unused_zero_a: assert property (rdCtl |-> prdata[31:14] == 18'h0 && !prdata[5])
        else $error("control unused bits not zero");
    poly_low_zero_a: assert property (rdPoly |-> prdata[31:16] == 16'h0 && !prdata[0])
        else $error("polynomial unused bits not zero");
    empty_flag_a: assert property (rdCtl |-> prdata[6] == (prdata[12:8] == 5'h00))
        else $error("empty flag disagrees with count");
    full_flag_a: assert property (rdCtl |-> prdata[7] == (prdata[12:8] == (prdata[3:0] > 4'h7 ? 5'h08 : 5'h10)))
        else $error("full flag disagrees with count");
    flags_apart_a: assert property (flagsApart)
        else $error("full and empty both set");
    count_long_a: assert property (rdCtl && prdata[3:0] > 4'h7 |-> prdata[12:8] <= 5'h08)
        else $error("count above eight for long words");
    count_short_a: assert property (rdCtl |-> prdata[12:8] <= 5'h10)
        else $error("count above sixteen");
    reset_quiet_a: assert property ($rose(rst_n) |-> !pready && !irq && !pslverr)
        else $error("outputs active right after reset");
    unmapped_zero_a: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0)
        else $error("unmapped read not zero");
    cover property (rdCtl && prdata[7]);
    cover property (pslverr);
    cover property ($rose(irq));
endmodule : crc_generator_chk

bind crc_generator crc_generator_chk chk_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

// File: testbench/testbench.sv
// Purpose: Self-checking bench for the CRC generator
// Assumes: Bench is the APB master; queue model of the FIFO
// Notes: Every CRC comparison runs at length sixteen
`timescale 1ns/1ps
module testbench;
    // ----------------------------------------
    // Signals, model and tasks
    // ----------------------------------------
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sleepReq = 1'b0, idleReq = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, irq, rerr;
    logic [15:0] mPoly = 16'h0, mCrc = 16'h0, w;
    logic [15:0] fifo[$];
    int error_cnt = 0, checks_done = 0, cyc = 0, mIdle = 0, mGo = 0, mLen = 0;
    always #2 clk = ~clk;
    crc_generator dut_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sleepReq(sleepReq), .idleReq(idleReq), .irq(irq));
    task complete_run;
        $display("Checks %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : complete_run
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task bus(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : bus
    task rd(input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask : rd
    function automatic logic [31:0] ctlExp();
        int c;
        int f;
        c = fifo.size();
        f = (c == (mLen > 7 ? 8 : 16)) ? 32'h80 : 32'h0;
        return 32'((mIdle << 13) | (c << 8) | f | ((c == 0) ? 32'h40 : 32'h0) | (mGo << 4) | mLen);
    endfunction : ctlExp
    task setCtl(input int i, input int g, input int l);
        mIdle = i;
        mGo = g;
        mLen = l;
        bus(1'b1, crc_gen_pkg::OFF_CONTROL, 32'((i << 13) | (g << 4) | l));
    endtask : setCtl
    // Writing into a full FIFO drops every word held
    task push;
        w = 16'($urandom);
        bus(1'b1, crc_gen_pkg::OFF_WDATA, {16'h0, w});
        if (fifo.size() == (mLen > 7 ? 8 : 16)) fifo.delete();
        else fifo.push_back(w);
    endtask : push
    task drain;
        do begin
            bus(1'b0, crc_gen_pkg::OFF_CONTROL, 32'h0);
        end while (rdat[6] !== 1'b1);
        foreach (fifo[k]) begin
            for (int i = 15; i >= 0; i--) begin
                mCrc = {mCrc[14:0], 1'b0} ^ ((mCrc[15] ^ fifo[k][i]) ? (mPoly | 16'h1) : 16'h0);
            end
        end
        fifo.delete();
        chk(rdat, ctlExp());
        rd(crc_gen_pkg::OFF_RESULT, {16'h0, mCrc});
    endtask : drain
    always @(posedge clk) begin
        cyc++;
        if (cyc == 10000) begin
            error_cnt++;
            complete_run();
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(89));
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rd(crc_gen_pkg::OFF_CONTROL, 32'h40);
        rd(crc_gen_pkg::OFF_POLY, 32'h0);
        chk({31'h0, rerr}, 32'h0);
        rd(12'h01C, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        bus(1'b1, crc_gen_pkg::OFF_POLY, 32'hFFFF_FFFF);
        rd(crc_gen_pkg::OFF_POLY, 32'hFFFE);
        mPoly = 16'h1020;
        bus(1'b1, crc_gen_pkg::OFF_POLY, 32'h1021);
        bus(1'b1, crc_gen_pkg::OFF_CONTROL, 32'hFFFF_FFFF, 4'h3);
        mIdle = 1;
        mGo = 1;
        mLen = 15;
        rd(crc_gen_pkg::OFF_CONTROL, ctlExp());
        for (int k = 0; k < 2; k++) begin
            setCtl(0, 0, k ? 15 : 7);
            repeat (k ? 9 : 17) begin
                push();
                rd(crc_gen_pkg::OFF_CONTROL, ctlExp());
            end
        end
        rd(crc_gen_pkg::OFF_IRQ_STAT, 32'h0);
        bus(1'b1, crc_gen_pkg::OFF_IRQ_MASK, 32'h1);
        repeat (3) push();
        repeat (60) @(posedge clk);
        // Low lane only: the top bit of a sixteen-bit word is not written
        bus(1'b1, crc_gen_pkg::OFF_WDATA, 32'h0000_00A5, 4'h1);
        rd(crc_gen_pkg::OFF_CONTROL, ctlExp());
        setCtl(0, 1, 15);
        setCtl(0, 0, 15);
        drain();
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, crc_gen_pkg::OFF_IRQ_STAT, 32'h1);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, crc_gen_pkg::OFF_IRQ_MASK, 32'h0);
        // Pass 0 sleeps, pass 1 idles while running, pass 2 idles halted
        for (int k = 0; k < 3; k++) begin
            setCtl(k / 2, 1, 15);
            if (k == 2) bus(1'b1, crc_gen_pkg::OFF_IRQ_MASK, 32'h1);
            push();
            sleepReq <= (k == 0);
            idleReq <= (k != 0);
            repeat (40) @(posedge clk);
            chk({31'h0, irq}, 32'(k / 2));
            rd(crc_gen_pkg::OFF_POWER, (k == 0) ? 32'h3 : ((k == 2) ? 32'h2 : 32'h0));
            if (k == 1) rd(crc_gen_pkg::OFF_CONTROL, 32'h5F);
            sleepReq <= 1'b0;
            idleReq <= 1'b0;
            @(posedge clk);
            if (k != 1) rd(crc_gen_pkg::OFF_CONTROL, ctlExp());
            drain();
            rd(crc_gen_pkg::OFF_IRQ_STAT, 32'h1);
        end
        bus(1'b1, crc_gen_pkg::OFF_IRQ_STAT, 32'h1);
        chk({31'h0, irq}, 32'h0);
        complete_run();
    end
endmodule : testbench
